//--- core/rmu_estimator.sv
// completion size estimate for one non-posted read
`timescale 1ns/1ps
module rmu_estimator
   import rmu_pkg::*;
#(
   parameter int CPL_LOG2 = RMU_CPL_LOG2_DEF
)
(
   input  wire logic [RMU_LEN_W-1:0]     len_dw,
   input  wire logic [RMU_OVR_W-1:0]     ovr,
   input  wire logic [RMU_LIM_W-1:0]     lim,
   output logic      [RMU_CNT_INT_W-1:0] est_int,
   output logic                          is_small
);

   localparam logic [11:0] CPL_ROUND = 12'((1 << CPL_LOG2) - 1);
   localparam logic [16:0] EST_MAX   = 17'((1 << RMU_CNT_INT_W) - 1);

   logic [11:0] len_up;
   logic [11:0] packets;
   logic [15:0] overhead;
   logic [16:0] sum;

   always_comb
   begin
      len_up   = {1'b0, len_dw} + CPL_ROUND;
      packets  = len_up >> CPL_LOG2;
      overhead = {12'h000, ovr} * {4'h0, packets};
      sum      = {6'h00, len_dw} + {1'b0, overhead};
      is_small = {1'b0, len_dw} <= {1'b0, lim};
      if (is_small)
         est_int = {3'h0, lim};
      else if (sum > EST_MAX)
         est_int = EST_MAX[RMU_CNT_INT_W-1:0];
      else
         est_int = sum[RMU_CNT_INT_W-1:0];
   end

endmodule

//--- core/rmu_meter.sv
// request metering unit: avalon register slave, counter and request gate
`timescale 1ns/1ps

// Notes on behaviour
// - meter only while the enable bit is set
// - four-bit overhead factor, resets to two
// - small reads use the fixed limit estimate
// - large reads estimate from completion packet count
// - counter drops every clock by adjustment
// - adjustment is 1:4:11 signed-magnitude, positive
// - counter is 24-bit unsigned 13.11
// - last loaded count kept read-only
// - count shown as 13.3 from counter top
// - lowest eight fractional load bits are zero
module rmu_meter
   import rmu_pkg::*;
#(
   parameter int CPL_LOG2 = RMU_CPL_LOG2_DEF
)
(
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire logic [11:0]          avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 req_valid,
   output logic                      req_ready,
   input  wire logic                 req_np_read,
   input  wire logic [RMU_LEN_W-1:0] req_len_dw,
   output logic                      fwd_valid,
   input  wire logic                 fwd_ready,
   output logic                      fwd_np_read,
   output logic      [RMU_LEN_W-1:0] fwd_len_dw,
   output logic                      meter_busy
);

   typedef struct packed {
      logic                      en;
      logic [RMU_OVR_W-1:0]      ovr;
      logic [RMU_LIM_W-1:0]      lim;
      logic [RMU_DADJ_W-1:0]     dadj;
      logic [RMU_CNT_W-1:0]      cnt;
      logic [RMU_LAST_W-1:0]     last;
      logic                      waitrq;
      logic [31:0]               rdata;
      logic                      req_rdy;
      logic                      fv;
      logic                      fnp;
      logic [RMU_LEN_W-1:0]      flen;
      logic                      busy;
   } rmu_state_s;

   localparam rmu_state_s RMU_STATE_RST = '{
      en:      RMU_EN_RST,
      ovr:     RMU_OVR_RST,
      lim:     RMU_LIM_RST,
      dadj:    RMU_DADJ_RST,
      cnt:     '0,
      last:    RMU_LAST_RST,
      waitrq:  1'b1,
      rdata:   32'h0000_0000,
      req_rdy: 1'b1,
      fv:      1'b0,
      fnp:     1'b0,
      flen:    '0,
      busy:    1'b0
   };

   rmu_state_s                s_q;
   rmu_state_s                s_d;

   logic [RMU_CNT_INT_W-1:0]  est_int;
   logic                      est_small;
   logic                      accept;
   logic                      load;
   logic                      bus_req;
   logic [RMU_CNT_W-1:0]      dec_amt;
   logic [RMU_CNT_W-1:0]      load_val;
   logic [31:0]               ctl_word;
   logic [31:0]               wr_mask;
   logic [31:0]               ctl_new;

   rmu_estimator #(
      .CPL_LOG2 (CPL_LOG2)
   ) u_est (
      .len_dw   (req_len_dw),
      .ovr      (s_q.ovr),
      .lim      (s_q.lim),
      .est_int  (est_int),
      .is_small (est_small)
   );

   always_comb
   begin
      s_d      = s_q;
      accept   = req_valid && s_q.req_rdy;
      load     = accept && req_np_read && s_q.en;
      bus_req  = avs_read || avs_write;

      // top bit of the adjustment is ignored: it is the sign, kept zero
      dec_amt  = {9'h000, s_q.dadj[RMU_DADJ_MAG_W-1:0]};
      // estimate is whole dwords, so the fractional part loads as zero
      load_val = {est_int, 11'h000};

      ctl_word = {s_q.dadj, s_q.lim, 1'b0, s_q.ovr, s_q.en};
      wr_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      ctl_new  = (ctl_word & ~wr_mask) | (avs_writedata & wr_mask);

      // one wait cycle per access, answer on the second cycle
      s_d.waitrq = !(bus_req && s_q.waitrq);
      if (avs_read && s_q.waitrq)
      begin
         unique case (avs_address[11:2])
            RMU_OFS_CTL[11:2]:  s_d.rdata = ctl_word;
            RMU_OFS_LAST[11:2]: s_d.rdata = {16'h0000, s_q.last};
            default:            s_d.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && !s_q.waitrq &&
          avs_address[11:2] == RMU_OFS_CTL[11:2])
      begin
         s_d.en   = ctl_new[RMU_EN_BIT];
         s_d.ovr  = ctl_new[RMU_OVR_LSB +: RMU_OVR_W];
         s_d.lim  = ctl_new[RMU_LIM_LSB +: RMU_LIM_W];
         s_d.dadj = ctl_new[RMU_DADJ_LSB +: RMU_DADJ_W];
      end

      // counter never wraps below zero; a zero adjustment never drains it
      if (load)
      begin
         s_d.cnt  = load_val;
         s_d.last = load_val[RMU_CNT_W-1:RMU_LAST_LSB];
      end
      else if (s_q.cnt > dec_amt)
         s_d.cnt = s_q.cnt - dec_amt;
      else
         s_d.cnt = '0;

      // single output slot: a request waits until the slot is drained
      if (accept)
      begin
         s_d.fv   = 1'b1;
         s_d.fnp  = req_np_read;
         s_d.flen = req_len_dw;
      end
      else if (fwd_ready)
         s_d.fv   = 1'b0;

      // in-order port, so posted traffic also waits behind a busy meter
      s_d.req_rdy = !s_d.fv && (!s_d.en || s_d.cnt == '0);
      s_d.busy    = s_d.cnt != '0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         s_q <= RMU_STATE_RST;
      else
         s_q <= s_d;
   end

   assign avs_readdata    = s_q.rdata;
   assign avs_waitrequest = s_q.waitrq;
   assign req_ready       = s_q.req_rdy;
   assign fwd_valid       = s_q.fv;
   assign fwd_np_read     = s_q.fnp;
   assign fwd_len_dw      = s_q.flen;
   assign meter_busy      = s_q.busy;

   // checks on the design's own behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   logic [RMU_CNT_W-1:0] exp_dec;
   assign exp_dec = {9'h000, s_q.dadj[RMU_DADJ_MAG_W-1:0]};

   // word decode seen from the bus side, used by the checks below
   logic                 hit_ctl;
   logic                 hit_last;
   assign hit_ctl  = avs_address[11:2] == RMU_OFS_CTL[11:2];
   assign hit_last = avs_address[11:2] == RMU_OFS_LAST[11:2];

   load_needs_en_a: assert property (
      load |-> s_q.en)
      else $error("meter loaded while metering disabled");

   off_no_load_a: assert property (
      (!s_q.en && s_q.cnt == '0 && !s_q.fv) |=> s_q.cnt == '0)
      else $error("counter moved while metering disabled");

   ovr_reset_a: assert property (
      $fell(sys_rst) |-> s_q.ovr == RMU_OVR_RST && s_q.lim == RMU_LIM_RST)
      else $error("control fields not at reset values");

   small_fixed_a: assert property (
      (load && est_small) |=>
         s_q.cnt[RMU_CNT_W-1:RMU_CNT_FRAC_W] == {3'h0, $past(s_q.lim)})
      else $error("small read did not load the fixed estimate");

   large_overhead_a: assert property (
      (load && !est_small) |=>
         s_q.cnt[RMU_CNT_W-1:RMU_CNT_FRAC_W] >=
         {2'b00, $past(req_len_dw)} + {9'h000, $past(s_q.ovr)})
      else $error("large read estimate lacks packet overhead");

   dec_step_a: assert property (
      (!load && s_q.cnt > exp_dec) |=>
         s_q.cnt == $past(s_q.cnt) - $past(exp_dec))
      else $error("counter did not step down by the adjustment");

   floor_zero_a: assert property (
      (!load && s_q.cnt <= exp_dec) |=> s_q.cnt == '0)
      else $error("counter wrapped or stalled above zero");

   frac_zero_a: assert property (
      load |=> s_q.cnt[RMU_LAST_LSB-1:0] == 8'h00)
      else $error("low fractional bits not zero after load");

   last_capture_a: assert property (
      load |=> s_q.last == s_q.cnt[RMU_CNT_W-1:RMU_LAST_LSB])
      else $error("captured count does not match loaded counter");

   hold_busy_a: assert property (
      (s_q.en && s_q.cnt != '0) |-> !req_ready)
      else $error("request admitted while meter busy");

   wait_one_a: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   wait_answer_a: assert property (
      (avs_read && avs_waitrequest) |=> !avs_waitrequest)
      else $error("read not answered on the following cycle");

   // register bus: answer timing, read decode and write landing
   idle_wait_a: assert property (
      (!avs_read && !avs_write) |=> avs_waitrequest)
      else $error("waitrequest dropped with no access pending");

   wait_write_a: assert property (
      (avs_write && avs_waitrequest) |=> !avs_waitrequest)
      else $error("write not answered on the following cycle");

   rd_ctl_a: assert property (
      (avs_read && avs_waitrequest && hit_ctl) |=>
         avs_readdata == $past(ctl_word))
      else $error("control read returned a stale word");

   rd_last_a: assert property (
      (avs_read && avs_waitrequest && hit_last) |=>
         avs_readdata == {16'h0000, $past(s_q.last)})
      else $error("count read returned a wrong word");

   rd_other_a: assert property (
      (avs_read && avs_waitrequest && !hit_ctl && !hit_last) |=>
         avs_readdata == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");

   rsvd_zero_a: assert property (
      (avs_read && avs_waitrequest && hit_ctl) |=>
         !avs_readdata[RMU_RSVD_BIT])
      else $error("reserved control bit read back as one");

   wr_ctl_a: assert property (
      (avs_write && !avs_waitrequest && hit_ctl &&
       avs_byteenable == 4'hf) |=>
         s_q.en == $past(avs_writedata[RMU_EN_BIT]) &&
         s_q.ovr == $past(avs_writedata[RMU_OVR_LSB +: RMU_OVR_W]) &&
         s_q.lim == $past(avs_writedata[RMU_LIM_LSB +: RMU_LIM_W]) &&
         s_q.dadj == $past(avs_writedata[RMU_DADJ_LSB +: RMU_DADJ_W]))
      else $error("full control write did not land");

   wr_last_a: assert property (
      (avs_write && hit_last && !load) |=> s_q.last == $past(s_q.last))
      else $error("write changed the read-only count");

   // ingress side: the single forward slot and the metering gate
   fwd_take_a: assert property (
      (req_valid && req_ready) |=> fwd_valid &&
         fwd_len_dw == $past(req_len_dw) &&
         fwd_np_read == $past(req_np_read))
      else $error("accepted request not forwarded intact");

   fwd_hold_a: assert property (
      (fwd_valid && !fwd_ready) |=> fwd_valid &&
         $stable(fwd_len_dw) && $stable(fwd_np_read))
      else $error("forwarded request changed before it was taken");

   fwd_drop_a: assert property (
      (fwd_valid && fwd_ready) |=> !fwd_valid)
      else $error("forward slot not emptied after hand-off");

   ready_full_a: assert property (
      fwd_valid |-> !req_ready)
      else $error("request admitted while forward slot full");

   ready_idle_a: assert property (
      (!s_q.en && !fwd_valid && !req_valid && !avs_write) |=> req_ready)
      else $error("disabled meter held back a request");

   drain_ready_a: assert property (
      (s_q.en && s_q.cnt != '0 && s_q.cnt <= exp_dec && !fwd_valid &&
       !avs_write) |=> req_ready)
      else $error("request still held after counter drained");

   busy_load_a: assert property (
      (load && est_int != '0) |=> meter_busy)
      else $error("loaded counter not reported busy");

   cnt_down_a: assert property (
      !load |=> s_q.cnt <= $past(s_q.cnt))
      else $error("counter rose without a load");

   posted_idle_a: assert property (
      (req_valid && req_ready && !req_np_read && s_q.cnt == '0) |=>
         s_q.cnt == '0)
      else $error("posted request loaded the counter");

   posted_keep_a: assert property (
      (req_valid && req_ready && !req_np_read) |=>
         s_q.last == $past(s_q.last))
      else $error("posted request changed the captured count");

   off_keep_a: assert property (
      (req_valid && req_ready && !s_q.en) |=> s_q.last == $past(s_q.last))
      else $error("disabled meter captured a count");

   large_limit_a: assert property (
      (load && !est_small) |=>
         s_q.cnt[RMU_CNT_W-1:RMU_CNT_FRAC_W] > {3'h0, $past(s_q.lim)})
      else $error("large read estimate not above the limit");

   // first edge after release: waitrequest, ready, forward valid and busy must show their idle levels
   rst_outputs_a: assert property (
      $fell(sys_rst) |-> avs_waitrequest && req_ready && !fwd_valid &&
         !meter_busy && !s_q.en && s_q.last == RMU_LAST_RST)
      else $error("outputs not at reset values after release");

endmodule

//--- include/rmu_pkg.sv
// constants shared by the request metering unit files
package rmu_pkg;

   // register byte offsets
   localparam logic [11:0] RMU_OFS_CTL       = 12'h880;
   localparam logic [11:0] RMU_OFS_LAST      = 12'h88c;

   // metering_control field positions and widths
   localparam int          RMU_EN_BIT        = 0;
   localparam int          RMU_OVR_LSB       = 1;
   localparam int          RMU_OVR_W         = 4;
   localparam int          RMU_RSVD_BIT      = 5;
   localparam int          RMU_LIM_LSB       = 6;
   localparam int          RMU_LIM_W         = 10;
   localparam int          RMU_DADJ_LSB      = 16;
   localparam int          RMU_DADJ_W        = 16;
   localparam int          RMU_DADJ_MAG_W    = 15;

   // metering_control reset values
   localparam logic        RMU_EN_RST        = 1'b0;
   localparam logic [3:0]  RMU_OVR_RST       = 4'h2;
   localparam logic [9:0]  RMU_LIM_RST       = 10'h010;
   localparam logic [15:0] RMU_DADJ_RST      = 16'h0000;

   // metering counter format 0:13:11 and captured count 13.3
   localparam int          RMU_CNT_W         = 24;
   localparam int          RMU_CNT_INT_W     = 13;
   localparam int          RMU_CNT_FRAC_W    = 11;
   localparam int          RMU_LAST_W        = 16;
   localparam int          RMU_LAST_LSB      = 8;
   localparam logic [15:0] RMU_LAST_RST      = 16'h0000;

   // request length in dwords and completion packet size
   localparam int          RMU_LEN_W         = 11;
   localparam int          RMU_CPL_LOG2_DEF  = 5;

endpackage

//--- sim/request_metering_unit_bench.sv
// self-checking bench for the request metering unit
`timescale 1ns/1ps
module request_metering_unit_bench
   import rmu_pkg::*;
;
   logic clk_sys, sys_rst, rd, wr, wait_q, fwd_v, fwd_rdy, fwd_np, busy;
   logic rv, rrdy, rnp;
   logic [11:0] adr;
   logic [3:0] be;
   logic [31:0] wd, rdat, q, st;
   logic [RMU_LEN_W-1:0] rlen, flen;
   int fails, tests_run, cyc, ovr, lim, adj, len, est, last, n, ed;
   int exp_len[$];
   int exp_np[$];
   rmu_meter u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_q), .req_valid(rv), .req_ready(rrdy),
      .req_np_read(rnp), .req_len_dw(rlen), .fwd_valid(fwd_v),
      .fwd_ready(fwd_rdy), .fwd_np_read(fwd_np), .fwd_len_dw(flen),
      .meter_busy(busy));
   rmu_requester u_req (.clk_sys(clk_sys), .req_ready(rrdy),
      .req_valid(rv), .req_np_read(rnp), .req_len_dw(rlen));
   function automatic int rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return int'(st[30:0]);
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d,
                      logic [3:0] m = 4'hf);
      @(posedge clk_sys);
      adr <= a;
      be <= m;
      wr <= w;
      rd <= ~w;
      wd <= d;
      do @(posedge clk_sys); while (wait_q !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // compose control word; bit 5 set on purpose, it must read back 0
   function automatic logic [31:0] ctl(int e);
      return {adj[15:0], lim[9:0], 1'b1, ovr[3:0], e[0]};
   endfunction
   task automatic print_verdict();
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // downstream stalls one cycle in four
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      fwd_rdy <= (cyc % 4) != 3;
      if (fwd_v === 1'b1 && fwd_rdy === 1'b1)
      begin
         chk("fwd_len", 32'(flen), 32'(exp_len.pop_front()));
         chk("fwd_np", 32'(fwd_np), 32'(exp_np.pop_front()));
      end
   end
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      fails++;
      print_verdict();
   end
   initial
   begin
      {rd, wr, adr, wd, be} = '0;
      st = 32'haa4c;
      sys_rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      bus(1'b0, RMU_OFS_CTL, '0);
      chk("ctl_rst", q, 32'h0000_0404);
      bus(1'b0, RMU_OFS_LAST, '0);
      chk("last_rst", q, '0);
      {ovr, lim, adj} = {32'd5, 32'd20, 32'h4800};
      bus(1'b1, RMU_OFS_LAST, 32'hffff_ffff);
      bus(1'b1, 12'h100, 32'hffff_ffff);
      bus(1'b0, 12'h100, '0);
      chk("unmapped", q, '0);
      bus(1'b1, RMU_OFS_CTL, ctl(0));
      bus(1'b0, RMU_OFS_CTL, '0);
      chk("ctl_rw", q, ctl(0) & ~32'h20);
      // upper lanes only: clears the adjustment, keeps the low half
      bus(1'b1, RMU_OFS_CTL, '0, 4'hc);
      bus(1'b0, RMU_OFS_CTL, '0);
      chk("ctl_be", q, ctl(0) & 32'h0000_ffdf);
      exp_len.push_back(100);
      exp_np.push_back(1);
      u_req.send(1'b1, 11'd100);
      #1 chk("idle_busy", 32'(busy), '0);
      bus(1'b0, RMU_OFS_LAST, '0);
      chk("last_off", q, '0);
      last = 0;
      for (int i = 0; i < 8; i++)
      begin
         ovr = rnd() % 16;
         lim = rnd() % 1023 + 1;
         adj = rnd() % 16384 + 16384;
         len = i == 0 ? lim : i == 1 ? lim + 1 : rnd() % 1024 + 1;
         if (len > 1024)
            len = 1024;
         est = len <= lim ? lim : len + ovr * ((len + 31) / 32);
         if (est > 8191)
            est = 8191;
         bus(1'b1, RMU_OFS_CTL, ctl(1));
         exp_len.push_back(len);
         exp_np.push_back(i != 7);
         u_req.send(i != 7, len[10:0]);
         n = 0;
         #1 while (busy === 1'b1)
         begin
            n++;
            @(posedge clk_sys);
            #1;
         end
         // posted requests neither load nor update the last count
         if (i != 7)
            last = est * 8;
         ed = i == 7 ? 0 : (est * 2048 + adj - 1) / adj;
         chk("drain", n, ed);
         bus(1'b0, RMU_OFS_LAST, '0);
         chk("last", q, last);
      end
      repeat (4) @(posedge clk_sys);
      chk("fwd_done", exp_len.size(), 0);
      print_verdict();
   end
endmodule

//--- sim/rmu_requester.sv
// requester model that offers ingress requests to the metering unit
`timescale 1ns/1ps
module rmu_requester
   import rmu_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 req_ready,
   output logic                      req_valid,
   output logic                      req_np_read,
   output logic      [RMU_LEN_W-1:0] req_len_dw
);
   initial
   begin
      req_valid = 1'b0;
      req_np_read = 1'b0;
      req_len_dw = '0;
   end
   // held until ready is seen, then the length lines turn over
   task automatic send(input logic np, input logic [RMU_LEN_W-1:0] len);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_np_read <= np;
      req_len_dw <= len;
      do @(posedge clk_sys); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      req_len_dw <= ~len;
   endtask
endmodule
